/* File: tlm_pkg.sv */
// Package of the tri-LED mode controller: register map, field layout,
// reset values, timing figures and carrier types.
// Assumes a 20 MHz device clock; blink, segment and stretch timing is counted in milliseconds.
package tlm_pkg;

  // ****************************************
  // Clock and time base
  // ****************************************
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned MS_PER_S = 1000;
  localparam int unsigned CYC_PER_MS_DFLT = CLK_HZ / MS_PER_S;

  // Durations in milliseconds.
  localparam logic [11:0] MS_42 = 12'd42;
  localparam logic [11:0] MS_84 = 12'd84;
  localparam logic [11:0] MS_170 = 12'd170;
  localparam logic [11:0] MS_340 = 12'd340;
  localparam logic [11:0] MS_670 = 12'd670;
  localparam logic [11:0] MS_1300 = 12'd1300;
  localparam logic [11:0] MS_2700 = 12'd2700;

  // ****************************************
  // Register map (byte addresses) and reset values
  // ****************************************
  localparam logic [7:0] OFS_FUNC = 8'h00;
  localparam logic [7:0] OFS_POLMIX = 8'h04;
  localparam logic [7:0] OFS_TIMER = 8'h08;
  localparam logic [7:0] OFS_STAT = 8'h0C;
  localparam logic [15:0] FUNC_RST = 16'h0000;
  localparam logic [15:0] POLMIX_RST = 16'h0015;
  localparam logic [15:0] TIMER_RST = 16'h0000;
  localparam logic [15:0] FUNC_MASK = 16'h0FFF;
  localparam logic [15:0] POLMIX_MASK = 16'hFF3F;
  localparam logic [15:0] TIMER_MASK = 16'h770F;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int unsigned FN_W = 4;
  localparam int unsigned POL_W = 2;
  localparam int unsigned MIX0_LSB = 8;
  localparam int unsigned MIX1_LSB = 12;
  localparam int unsigned ODD_LSB = 0;
  localparam int unsigned EVEN_LSB = 2;
  localparam int unsigned BLINK_LSB = 8;
  localparam int unsigned STRETCH_LSB = 12;

  // ****************************************
  // Function codes
  // ****************************************
  localparam logic [1:0] FN_MANUAL = 2'b10;
  localparam logic [1:0] FN_DUAL = 2'b11;
  localparam logic [1:0] MAN_OFF = 2'b00;
  localparam logic [1:0] MAN_ON = 2'b01;
  localparam logic [1:0] MAN_HIZ = 2'b10;
  localparam logic [1:0] MAN_BLINK = 2'b11;
  localparam logic [3:0] FN_SPEED_BLINK = 4'h2;
  localparam logic [3:0] MIX_FULL = 4'h8;
  localparam logic [2:0] SEG_LAST = 3'h7;

  typedef enum logic [1:0] {
    TLM_MODE1,
    TLM_MODE2,
    TLM_MODE3,
    TLM_MODE4
  } tlm_dual_mode_t;

  // Status from the transceiver core.
  typedef struct packed {
    logic link10;
    logic link100;
    logic link1000;
    logic fiber_link;
    logic full_duplex;
    logic collision;
    logic tx_act;
    logic rx_act;
  } tlm_phy_status_t;

  // Pin level and output enable of the three LED pins.
  typedef struct packed {
    logic [2:0] drive;
    logic [2:0] oe;
  } tlm_led_pins_t;

endpackage

/* File: tlm_stretch.sv */
// Pulse stretcher for one activity strobe.
// Assumes a one-cycle millisecond tick from the caller; length 0 passes through.
`timescale 1ns/1ns
module tlm_stretch (
  // Clock and reset
  input wire logic CLK_IN,
  input wire logic RST_IN,
  // Time base and setting
  input wire logic ms_tick_in,
  input wire logic [11:0] len_ms_in,
  // Activity
  input wire logic act_in,
  output logic act_out
);

  logic [11:0] left_q;

  // Restarting on every strobe keeps the lamp lit for the whole burst.
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      left_q <= 12'h000;
    end else if (act_in) begin
      left_q <= len_ms_in;
    end else if (ms_tick_in && left_q != 12'h000) begin
      left_q <= left_q - 12'h001;
    end
  end

  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      act_out <= 1'b0;
    end else begin
      act_out <= act_in || (left_q > 12'h001) || (left_q == 12'h001 && !ms_tick_in);
    end
  end

endmodule

/* File: tlm_led_ctrl.sv */
// Tri-LED mode controller: APB registers, function decode, blink, speed
// blink, bi-colour mixing and pin polarity for three LED pins.
// Assumes status inputs synchronous to CLK_IN; pad logic resolves drive/oe.
// What this block does
// - Dual modes blend the two lower LEDs into a third colour.
// - Mix is the on-time share per LED, one 4-bit field each.
// - Mix codes step 12.5 percent, 8 is full on, above reserved.
// - Mixing only when LED zero function is 11xx.
// - LED two function codes: link, activity, duplex, transmit, speeds.
// - LED one function codes: receive, activity, 100 or fiber links.
// - LED one function ignored while LED zero is in dual mode.
// - LED zero function codes include speed blink, copper and gigabit link.
// - Codes 10xx force off, on, Hi-Z or blink.
// - Compound activity is transmit OR receive.
// - Compound link is OR of the three copper speed links.
// - Speed blink: eight segments, pulses encode the link speed.
// - Odd segments use odd period field, even use even field.
// - Segment periods are 84, 170, 340 or 670 ms.
// - Manual override lights only one colour.
// - First dual mode shows steady mixed colour.
// - Second dual mode blinks the mixed colour.
// - Third dual mode codes speed by colour, blinking on activity.
// - Fourth dual mode swaps the 10 and 100 indications.
// - Stretch, then blink, then mix, then apply polarity.
// - Polarity low bit sets on level, high bit tristates off.
// - Blink rate codes 42 to 670 ms, upper codes reserved.
//
// Our own choices: the APB register port and the address map.
`timescale 1ns/1ns
module tlm_led_ctrl #(
  parameter int unsigned CYC_PER_MS = tlm_pkg::CYC_PER_MS_DFLT
) (
  // Clock and reset
  input wire logic CLK_IN,
  input wire logic RST_IN,
  // APB slave
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [7:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  output logic [31:0] PRDATA_OUT,
  output logic PREADY_OUT,
  output logic PSLVERR_OUT,
  // Transceiver status
  input wire tlm_pkg::tlm_phy_status_t STATUS_IN,
  // LED pins
  output tlm_pkg::tlm_led_pins_t LED_OUT
);
  import tlm_pkg::*;

  // ****************************************
  // Registers
  // ****************************************
  logic [15:0] func_q;
  logic [15:0] polmix_q;
  logic [15:0] timer_q;
  logic [31:0] prdata_q;
  logic [2:0] led_on_q;
  logic [2:0] led_drive_q;
  logic [2:0] led_oe_q;
  logic wr_en;
  logic rd_setup;
  logic mapped;

  function automatic logic is_mapped(input logic [7:0] a);
    return a == OFS_FUNC || a == OFS_POLMIX || a == OFS_TIMER || a == OFS_STAT;
  endfunction

  assign mapped = is_mapped(PADDR_IN);
  assign wr_en = PSEL_IN && PENABLE_IN && PWRITE_IN && mapped;
  assign rd_setup = PSEL_IN && !PENABLE_IN && !PWRITE_IN;
  assign PREADY_OUT = 1'b1;
  assign PSLVERR_OUT = PSEL_IN && PENABLE_IN && !mapped;
  assign PRDATA_OUT = prdata_q;

  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      func_q <= FUNC_RST;
      polmix_q <= POLMIX_RST;
      timer_q <= TIMER_RST;
    end else if (wr_en) begin
      case (PADDR_IN)
        OFS_FUNC: func_q <= PWDATA_IN[15:0] & FUNC_MASK;
        OFS_POLMIX: polmix_q <= PWDATA_IN[15:0] & POLMIX_MASK;
        OFS_TIMER: timer_q <= PWDATA_IN[15:0] & TIMER_MASK;
        default: func_q <= func_q;
      endcase
    end
  end

  // ****************************************
  // Millisecond time base
  // ****************************************
  logic [15:0] pre_q;
  logic ms_tick;

  assign ms_tick = pre_q == 16'(CYC_PER_MS - 1);

  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      pre_q <= 16'h0000;
    end else begin
      pre_q <= ms_tick ? 16'h0000 : pre_q + 16'h0001;
    end
  end

  // ****************************************
  // Status: stretch then compound
  // ****************************************
  logic tx_s;
  logic rx_s;
  logic act;
  logic link;

  function automatic logic [11:0] stretch_ms(input logic [2:0] c);
    case (c)
      3'h1: return MS_42;
      3'h2: return MS_84;
      3'h3: return MS_170;
      3'h4: return MS_340;
      3'h5: return MS_670;
      3'h6: return MS_1300;
      3'h7: return MS_2700;
      default: return 12'h000;
    endcase
  endfunction

  // Stretching ahead of blink and mix.
  tlm_stretch u_tx_str (
    .CLK_IN(CLK_IN),
    .RST_IN(RST_IN),
    .ms_tick_in(ms_tick),
    .len_ms_in(stretch_ms(timer_q[STRETCH_LSB +: 3])),
    .act_in(STATUS_IN.tx_act),
    .act_out(tx_s)
  );

  tlm_stretch u_rx_str (
    .CLK_IN(CLK_IN),
    .RST_IN(RST_IN),
    .ms_tick_in(ms_tick),
    .len_ms_in(stretch_ms(timer_q[STRETCH_LSB +: 3])),
    .act_in(STATUS_IN.rx_act),
    .act_out(rx_s)
  );

  assign act = tx_s || rx_s;
  assign link = STATUS_IN.link10 || STATUS_IN.link100 || STATUS_IN.link1000;

  // ****************************************
  // Blink phase
  // ****************************************
  logic [11:0] blink_ms_q;
  logic blink_q;
  logic [11:0] blink_len;

  // Reserved rates fall back to the slowest one.
  function automatic logic [11:0] blink_period(input logic [2:0] c);
    case (c)
      3'h0: return MS_42;
      3'h1: return MS_84;
      3'h2: return MS_170;
      3'h3: return MS_340;
      default: return MS_670;
    endcase
  endfunction

  assign blink_len = blink_period(timer_q[BLINK_LSB +: 3]);

  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      blink_ms_q <= 12'h000;
      blink_q <= 1'b0;
    end else if (ms_tick) begin
      if (blink_ms_q >= blink_len - 12'h001) begin
        blink_ms_q <= 12'h000;
        blink_q <= !blink_q;
      end else begin
        blink_ms_q <= blink_ms_q + 12'h001;
      end
    end
  end

  // ****************************************
  // Speed blink sequencer
  // ****************************************
  logic [2:0] seg_q;
  logic [11:0] seg_ms_q;
  logic [11:0] seg_len;
  logic seg_done;
  logic speed_on;

  function automatic logic [11:0] seg_period(input logic [1:0] c);
    case (c)
      2'h0: return MS_84;
      2'h1: return MS_170;
      2'h2: return MS_340;
      default: return MS_670;
    endcase
  endfunction

  // Index 0 is segment 1, so even indices are odd segments.
  assign seg_len = seg_q[0] ? seg_period(timer_q[EVEN_LSB +: 2]) : seg_period(timer_q[ODD_LSB +: 2]);
  assign seg_done = ms_tick && seg_ms_q >= seg_len - 12'h001;

  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      seg_q <= 3'h0;
      seg_ms_q <= 12'h000;
    end else if (seg_done) begin
      seg_q <= seg_q + 3'h1;
      seg_ms_q <= 12'h000;
    end else if (ms_tick) begin
      seg_ms_q <= seg_ms_q + 12'h001;
    end
  end

  // Three, two, one or no pulses by speed.
  assign speed_on = (seg_q == 3'h0 && link) ||
                    (seg_q == 3'h2 && (STATUS_IN.link100 || STATUS_IN.link1000)) ||
                    (seg_q == 3'h4 && STATUS_IN.link1000);

  // ****************************************
  // Mixing
  // ****************************************
  logic [2:0] pwm_q;
  logic mix0_on;
  logic mix1_on;

  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      pwm_q <= 3'h0;
    end else begin
      pwm_q <= pwm_q + 3'h1;
    end
  end

  // Eighth steps; code 8 and above never compares false.
  assign mix0_on = {1'b0, pwm_q} < polmix_q[MIX0_LSB +: 4];
  assign mix1_on = {1'b0, pwm_q} < polmix_q[MIX1_LSB +: 4];

  // ****************************************
  // Function decode
  // ****************************************
  function automatic logic single_on(input int unsigned pin, input logic [3:0] c, input tlm_phy_status_t st,
                                     input logic lk, input logic ac, input logic tx, input logic rx,
                                     input logic bl, input logic sp);
    case (c)
      4'h0: return pin == 1 ? rx : lk;
      4'h1: return lk && (!ac || bl);
      4'h2: begin
        if (pin == 2) begin
          return st.full_duplex && (!st.collision || bl);
        end else if (pin == 1) begin
          return lk && (!rx || bl);
        end
        return sp;
      end
      4'h3: return ac;
      4'h4: return ac && bl;
      4'h5: return pin == 1 ? (st.link100 || st.fiber_link) : tx;
      4'h6: begin
        if (pin == 2) begin
          return st.link10 || st.link1000;
        end else if (pin == 1) begin
          return st.link100 || st.link1000;
        end
        return lk;
      end
      4'h7: return pin == 2 ? st.link10 : (pin == 1 ? st.link100 : st.link1000);
      4'h8: return 1'b0;
      4'h9: return 1'b1;
      4'hB: return bl;
      default: return 1'b0;
    endcase
  endfunction

  logic [2:0] on_d;
  logic [2:0] hiz_d;
  logic dual;
  tlm_dual_mode_t mode;
  logic s1000;
  logic s100;
  logic s10;
  logic gate;
  logic solo0;
  logic solo1;
  logic mixsel;

  assign dual = func_q[3:2] == FN_DUAL;
  assign mode = tlm_dual_mode_t'(func_q[1:0]);
  assign s1000 = STATUS_IN.link1000;
  assign s100 = STATUS_IN.link100 && !s1000;
  assign s10 = STATUS_IN.link10 && !STATUS_IN.link100 && !s1000;
  assign gate = !act || blink_q;
  assign solo0 = s1000;
  assign solo1 = mode == TLM_MODE3 ? s10 : s100;
  assign mixsel = mode == TLM_MODE3 ? s100 : s10;

  genvar gi;
  for (gi = 0; gi < 3; gi++) begin : g_pin
    logic [3:0] fn;
    logic on_s;
    assign fn = func_q[gi * FN_W +: FN_W];
    // Manual codes share the decoder and drive one pin only.
    assign on_s = single_on(gi, fn, STATUS_IN, link, act, tx_s, rx_s, blink_q, speed_on);
    if (gi == 2) begin : g_single
      assign on_d[gi] = on_s;
      assign hiz_d[gi] = fn == {FN_MANUAL, MAN_HIZ};
    end else begin : g_dual
      logic mix_on;
      logic solo;
      logic on_dual;
      assign mix_on = gi == 0 ? mix0_on : mix1_on;
      assign solo = gi == 0 ? solo0 : solo1;
      always_comb begin
        case (mode)
          TLM_MODE1: on_dual = mix_on;
          TLM_MODE2: on_dual = mix_on && blink_q;
          default: on_dual = gate && (solo || (mixsel && mix_on));
        endcase
      end
      // Dual overrides both lower pins and ignores the middle field.
      assign on_d[gi] = dual ? on_dual : on_s;
      assign hiz_d[gi] = !dual && fn == {FN_MANUAL, MAN_HIZ};
    end
  end

  // ****************************************
  // Polarity and output registers
  // ****************************************
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      led_on_q <= 3'h0;
      led_drive_q <= 3'h0;
      led_oe_q <= 3'h0;
    end else begin
      led_on_q <= on_d;
      for (int i = 0; i < 3; i++) begin
        led_drive_q[i] <= polmix_q[i * POL_W] ? on_d[i] : !on_d[i];
        led_oe_q[i] <= !hiz_d[i] && (on_d[i] || !polmix_q[i * POL_W + 1]);
      end
    end
  end

  assign LED_OUT.drive = led_drive_q;
  assign LED_OUT.oe = led_oe_q;

  // Read data is captured in the setup cycle, so the access needs no wait.
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      prdata_q <= 32'h0000_0000;
    end else if (rd_setup) begin
      case (PADDR_IN)
        OFS_FUNC: prdata_q <= {16'h0000, func_q};
        OFS_POLMIX: prdata_q <= {16'h0000, polmix_q};
        OFS_TIMER: prdata_q <= {16'h0000, timer_q};
        OFS_STAT: prdata_q <= {23'h000000, blink_q, seg_q, act, link, led_on_q};
        default: prdata_q <= 32'h0000_0000;
      endcase
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (RST_IN);

  sequence s_seg_end;
    seg_done && seg_q == SEG_LAST;
  endsequence

  // Stretched activity reaches the pin one edge after the strobe is sampled.
  sequence s_rx_seen;
    func_q[11:8] == 4'h3 && STATUS_IN.rx_act ##1 func_q[11:8] == 4'h3;
  endsequence

  // The pin level was formed from the polarity of the previous cycle.
  a_force_on_drive: assert property (func_q[11:8] == 4'h9 |=>
                                     led_oe_q[2] && led_drive_q[2] == $past(polmix_q[4]))
    else $error("forced-on pin not lit");
  a_force_hiz_oe: assert property (func_q[11:8] == 4'hA |=> !led_oe_q[2])
    else $error("forced Hi-Z pin driven");
  a_link_or_on: assert property (func_q[11:8] == 4'h0 && STATUS_IN.link100 |=> led_on_q[2])
    else $error("compound link not shown");
  a_act_or_on: assert property (s_rx_seen |=> led_on_q[2])
    else $error("compound activity not shown");
  a_mix_zero_off: assert property (dual && mode == TLM_MODE1 && polmix_q[11:8] == 4'h0 |=> !led_on_q[0])
    else $error("zero mix lit LED zero");
  a_mix_full_on: assert property (dual && mode == TLM_MODE1 && polmix_q[15:12] == MIX_FULL |=> led_on_q[1])
    else $error("full mix not solid");
  a_dual_ignores_one: assert property (dual && func_q[7:4] == 4'h9 && mode == TLM_MODE1 &&
                                       polmix_q[15:12] == 4'h0 |=> !led_on_q[1])
    else $error("middle field acted in dual mode");
  a_speed_nolink: assert property (func_q[3:0] == FN_SPEED_BLINK && !link |=> !led_on_q[0])
    else $error("speed blink lit without link");
  a_seg_wrap: assert property (s_seg_end |=> seg_q == 3'h0 && seg_ms_q == 12'h000)
    else $error("segment sequence did not wrap");
  // A shortened period may leave the count high until the next tick; only steady settings are checked.
  a_seg_len_cap: assert property ($stable(timer_q) && $stable(seg_q) && $past(seg_ms_q) < seg_len |->
                                  seg_ms_q < seg_len)
    else $error("segment ran past its period");
  a_pol_tristate_off: assert property (!on_d[2] && polmix_q[5] |=> !led_oe_q[2])
    else $error("off state driven with tristate polarity");
  a_mode3_gig: assert property (dual && mode == TLM_MODE3 && s1000 && !act |=> led_on_q == {led_on_q[2], 2'b01})
    else $error("gigabit colour wrong in mode 3");
  a_mode4_fast: assert property (dual && mode == TLM_MODE4 && s100 && !act |=> led_on_q[1:0] == 2'b10)
    else $error("100 colour wrong in mode 4");

endmodule

/* File: tlm_led_model.sv */
// Model of discrete or bi-colour LEDs hung on the three LED pins.
// Assumes active-high wiring (anode on the pin); counts lit cycles in a window.
`timescale 1ns/1ns
module tlm_led_model (
  // Clock
  input wire logic CLK_IN,
  // Pins and count window
  input wire tlm_pkg::tlm_led_pins_t led_in,
  input wire logic en_in,
  output logic [2:0][15:0] cnt_out
);
  import tlm_pkg::*;
  logic en_q;
  logic [2:0] lit;
  // ****************************************
  // Lamp current and on-time counters
  // ****************************************
  // A released pin leaves the lamp dark, so Hi-Z never counts as lit.
  assign lit = led_in.oe & led_in.drive;
  always_ff @(posedge CLK_IN) begin
    en_q <= en_in;
    for (int i = 0; i < 3; i++) begin
      if (en_in && !en_q) begin
        cnt_out[i] <= 16'(lit[i]);
      end else if (en_in) begin
        cnt_out[i] <= cnt_out[i] + 16'(lit[i]);
      end
    end
  end
endmodule

/* File: tlm_led_ctrl_tb.sv */
// Self-checking bench of the tri-LED mode controller over APB.
// Assumes a shortened millisecond of 4 clocks; windows are whole periods.
`timescale 1ns/1ns
module tlm_led_ctrl_tb;
  import tlm_pkg::*;
  localparam int unsigned CPM = 4;
  localparam int LIMIT = 60000;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  tlm_phy_status_t stat = '0;
  tlm_led_pins_t led;
  logic en = 1'b0;
  logic [2:0][15:0] cnt;
  logic [31:0] rdat;
  logic err;
  int failures = 0;
  int tests_run = 0;
  int cyc = 0;
  logic [7:0] rofs [3] = '{OFS_FUNC, OFS_POLMIX, OFS_TIMER};
  logic [15:0] rrst [3] = '{FUNC_RST, POLMIX_RST, TIMER_RST};
  logic [15:0] rmsk [3] = '{FUNC_MASK, POLMIX_MASK, TIMER_MASK};
  logic [15:0] sfn [10] = '{16'h0000, 16'h0000, 16'h0300, 16'h0333, 16'h0656, 16'h0777, 16'h0777, 16'h0250,
                            16'h0250, 16'h0566};
  logic [7:0] sst [10] = '{8'h80, 8'h20, 8'h01, 8'h02, 8'h40, 8'h80, 8'h20, 8'h10, 8'h08, 8'h20};
  logic [2:0] sdr [10] = '{3'h5, 3'h5, 3'h6, 3'h7, 3'h3, 3'h4, 3'h1, 3'h2, 3'h4, 3'h3};
  logic [15:0] dfn [11] = '{16'h008C, 16'h008D, 16'h008E, 16'h008E, 16'h008E, 16'h008E, 16'h008E, 16'h008F,
                            16'h008F, 16'h008F, 16'h0099};
  logic [7:0] dst [11] = '{8'h00, 8'h00, 8'h20, 8'h40, 8'h80, 8'h00, 8'h22, 8'h40, 8'h80, 8'h81, 8'h00};
  logic [15:0] de1 [11] = '{16'd672, 16'd336, 16'd0, 16'd672, 16'd1344, 16'd0, 16'd0, 16'd1344, 16'd672, 16'd336,
                            16'd1344};
  logic [15:0] de0 [11] = '{16'd672, 16'd336, 16'd1344, 16'd672, 16'd0, 16'd0, 16'd672, 16'd0, 16'd672, 16'd336,
                            16'd1344};
  logic [7:0] pst [4] = '{8'h20, 8'h40, 8'h80, 8'h00};
  logic [15:0] pexp [4] = '{16'd1008, 16'd672, 16'd336, 16'd0};

  always #25 clk = ~clk;

  tlm_led_ctrl #(.CYC_PER_MS(CPM)) i_tlm_led_ctrl (.CLK_IN(clk), .RST_IN(rst), .PSEL_IN(psel),
    .PENABLE_IN(penable), .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
    .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .STATUS_IN(stat), .LED_OUT(led));
  tlm_led_model i_tlm_led_model (.CLK_IN(clk), .led_in(led), .en_in(en), .cnt_out(cnt));

  // ****************************************
  // Reporting
  // ****************************************
  task automatic wrap_up;
    $display("failures=%0d tests_run=%0d", failures, tests_run);
    if (failures == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic cmp_w(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t value %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp_n(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t lit count %0d expected %0d", $time, got, exp);
    end
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == LIMIT) begin
      failures++;
      wrap_up();
    end
  end

  // ****************************************
  // Bus and stimulus tasks
  // ****************************************
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rdat = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic set(input logic [15:0] fn, input logic [7:0] st);
    apb(1'b1, OFS_FUNC, {16'h0000, fn});
    stat <= st;
    repeat (4) @(posedge clk);
    @(negedge clk);
  endtask
  // The window is n samples; a pulse run sends one transmit strobe at its start.
  task automatic meas(input int n, input logic pulse);
    @(posedge clk);
    en <= 1'b1;
    if (pulse) begin
      @(posedge clk);
      stat.tx_act <= 1'b1;
      @(posedge clk);
      stat.tx_act <= 1'b0;
      repeat (n - 2) @(posedge clk);
    end else begin
      repeat (n) @(posedge clk);
    end
    en <= 1'b0;
    @(negedge clk);
  endtask

  // ****************************************
  // Test sequence
  // ****************************************
  initial begin
    logic on;
    logic hz;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 3; i++) begin
      apb(1'b0, rofs[i], 32'h00000000);
      cmp_w(rdat, {16'h0000, rrst[i]});
      apb(1'b1, rofs[i], 32'hFFFFFFFF);
      apb(1'b0, rofs[i], 32'h00000000);
      cmp_w({rdat[31:1], err}, {16'h0000, rmsk[i][15:1], 1'b0});
    end
    apb(1'b1, 8'h10, 32'hFFFFFFFF);
    apb(1'b0, 8'h10, 32'h00000000);
    cmp_w({rdat[31:1], err}, 32'h00000001);
    apb(1'b1, OFS_TIMER, 32'h00000100);
    for (int c = 0; c < 3; c++) begin
      for (int p = 0; p < 4; p++) begin
        apb(1'b1, OFS_POLMIX, {16'h0000, 8'h44, 2'b00, 2'(p), 4'h5});
        set({4'h0, FN_MANUAL, 2'(c), 8'h00}, 8'h00);
        on = (c == 1);
        hz = (c == 2);
        cmp_w({30'h0, led.drive[2], led.oe[2]}, {30'h0, p[0] ? on : !on, !hz && (on || !p[1])});
      end
    end
    // Both mix shares stay at half, so the two lower pins light together in the same half of each eight-cycle frame.
    apb(1'b1, OFS_POLMIX, 32'h00004415);
    for (int i = 0; i < 10; i++) begin
      set(sfn[i], sst[i]);
      cmp_w({26'h0, led}, {26'h0, sdr[i], 3'h7});
    end
    // Blink phase and segment index run freely, so only the steady status bits are compared.
    apb(1'b0, OFS_STAT, 32'h00000000);
    cmp_w(rdat & 32'hFFFFFE1F, 32'h0000000B);
    set(16'h000B, 8'h00);
    meas(1344, 1'b0);
    cmp_n(cnt[0], 16'd672);
    for (int i = 0; i < 11; i++) begin
      set(dfn[i], dst[i]);
      meas(1344, 1'b0);
      cmp_n(cnt[1], de1[i]);
      cmp_n(cnt[0], de0[i]);
    end
    apb(1'b1, OFS_POLMIX, 32'h00008015);
    set(16'h008C, 8'h00);
    meas(1344, 1'b0);
    cmp_n(cnt[1], 16'd1344);
    cmp_n(cnt[0], 16'd0);
    apb(1'b1, OFS_POLMIX, 32'h00000815);
    set(16'h009C, 8'h00);
    meas(1344, 1'b0);
    cmp_n(cnt[1], 16'd0);
    cmp_n(cnt[0], 16'd1344);
    apb(1'b1, OFS_TIMER, 32'h00000104);
    for (int k = 0; k < 4; k++) begin
      set(16'h0002, pst[k]);
      meas(4064, 1'b0);
      cmp_n(cnt[0], pexp[k]);
    end
    apb(1'b1, OFS_TIMER, 32'h00001100);
    set(16'h0300, 8'h00);
    meas(400, 1'b1);
    cmp_w(32'(cnt[2] >= 16'd84 && cnt[2] <= 16'd172), 32'h00000001);
    wrap_up();
  end
endmodule
